// ### ramp_seq_pkg.sv
/*
  Shared constants, command codes, reset values, field layout and the
  Linear-11 to clock-cycle conversion for the output ramp sequencer.
  Assumes a 250 MHz core clock; nothing here holds state.
*/
package ramp_seq_pkg;
  // ==========================================================
  // Command codes of the sequencing registers
  localparam logic [7:0] CMD_PG_THRESH = 8'h5E;
  localparam logic [7:0] CMD_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_RISE = 8'h61;
  localparam logic [7:0] CMD_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_FALL = 8'h65;
  // ==========================================================
  // Field layout and reset values
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;
  localparam logic [15:0] TIME_RESET = 16'hCA80; // 5 ms
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam int PG_NUM = 9; // Threshold default is 0.9 of setpoint
  localparam int PG_DEN = 10;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_PS = 1000000000;
  localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;
  localparam int FALL_MIN_MS = 5;
  localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;

  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ON_DLY, ST_RISE, ST_ON, ST_OFF_DLY, ST_FALL
  } seq_state_e;

  // Time in cycles of a Linear-11 code; negative mantissa counts as zero
  function automatic logic [63:0] lin11Cycles(input logic [15:0] code,
                                              input logic [31:0] cpm);
    logic [4:0] e;
    logic [63:0] base;
    e = code[EXP_MSB:EXP_LSB];
    base = code[MANT_MSB] ? 64'h0 : {53'h0, code[MANT_MSB:0]} * {32'h0, cpm};
    if (e[4]) begin
      lin11Cycles = base >> (6'd32 - {1'b0, e});
    end else begin
      lin11Cycles = base << e;
    end
  endfunction
endpackage

// ### lin11_timer.sv
/*
  One-shot timer loaded with a Linear-11 millisecond code.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module lin11_timer #(
  parameter int CycPerMs = ramp_seq_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] code,
  output logic done
);
  logic [31:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [63:0] loadCyc;
  logic [31:0] loadCnt;

  // Saturate: 5 s is 1.25e9 cycles, so 32 bits always suffice in range
  assign loadCyc = ramp_seq_pkg::lin11Cycles(code, 32'(CycPerMs));
  assign loadCnt = (loadCyc > {32'h0, ramp_seq_pkg::CNT_MAX}) ?
                   ramp_seq_pkg::CNT_MAX : loadCyc[31:0];
  assign done = done_r;

  // ==========================================================
  // Countdown; done pulses once when the count runs out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= loadCnt;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= 32'h1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end
endmodule

// ### output_ramp_sequencer.sv
/*
  Output turn-on/turn-off sequencer with power-good hysteresis and the
  five sequencing registers behind a command-level port.
  Assumes command, measurement and enable inputs come from logic on clk.
*/
// What this block does
// - Power-good sets above threshold, clears below undervoltage fault limit.
// - Threshold is unsigned Linear-16; reset value is 0.9 of strapped setpoint.
// - On enable, wait turn-on delay (ms, 0 to 5 s) before rising.
// - All four timing registers reset to CA80h, meaning 5 ms.
// - Two-phase mode ramps up over rise time after turn-on delay.
// - Multi-phase mode ignores rise time; external ramp gain logic paces rise.
// - On disable, wait turn-off delay (ms, 0 to 5 s) before falling.
// - Controlled fall over fall time only in two-phase mode.
// - Fall time under 5 ms: switches off right after turn-off delay.
// - Multi-phase: always switches off right after turn-off delay.
// - All five registers read/write and blocked by write protection.
// - Timing value in ms is mantissa times two to the exponent.
`timescale 1ns/1ps
module output_ramp_sequencer #(
  parameter int CycPerMs = ramp_seq_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmdValid,
  input wire ramp_seq_pkg::cmd_s cmd,
  input wire logic writeProtect,
  input wire logic outputEnable,
  input wire logic multiPhase,
  input wire logic multiRampDone,
  input wire logic [15:0] setpointStrap,
  input wire logic [15:0] voutMeas,
  input wire logic [15:0] uvFaultLimit,
  output logic [15:0] rdata,
  output logic rdataValid,
  output logic rampUp,
  output logic rampDown,
  output logic outputOn,
  output logic switchesOff,
  output logic powerGood
);
  // Refuse a clock rate that leaves no whole cycle per millisecond
  if (CycPerMs < 1) begin : g_badRate
    $error("CycPerMs must be at least 1");
  end

  ramp_seq_pkg::seq_state_e state_r, state_nxt;
  logic [15:0] pgThresh_r, onDly_r, rise_r, offDly_r, fall_r;
  logic [15:0] rdata_r, rdataSel;
  logic rdataValid_r, pg_r, rampUp_r, rampDown_r, on_r, off_r;
  logic timerStart, timerDone;
  logic [15:0] timerCode;
  logic wrOk, fallShort, hardOff;
  logic [19:0] strapProd;

  // ==========================================================
  // Register access
  // Writes are dropped silently while protected; reads stay open
  assign wrOk = cmdValid && cmd.write && !writeProtect;
  assign strapProd = 20'(setpointStrap * 20'(ramp_seq_pkg::PG_NUM));
  assign rdataSel = (cmd.code == ramp_seq_pkg::CMD_PG_THRESH) ? pgThresh_r :
                    (cmd.code == ramp_seq_pkg::CMD_ON_DELAY) ? onDly_r :
                    (cmd.code == ramp_seq_pkg::CMD_RISE) ? rise_r :
                    (cmd.code == ramp_seq_pkg::CMD_OFF_DELAY) ? offDly_r :
                    (cmd.code == ramp_seq_pkg::CMD_FALL) ? fall_r :
                    ramp_seq_pkg::ZERO16;

  // Strap sampled at reset with the synchronous reset, not asynchronously
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pgThresh_r <= 16'(strapProd / 20'(ramp_seq_pkg::PG_DEN));
      onDly_r <= ramp_seq_pkg::TIME_RESET;
      rise_r <= ramp_seq_pkg::TIME_RESET;
      offDly_r <= ramp_seq_pkg::TIME_RESET;
      fall_r <= ramp_seq_pkg::TIME_RESET;
    end else if (ce && wrOk) begin
      case (cmd.code)
        ramp_seq_pkg::CMD_PG_THRESH: pgThresh_r <= cmd.wdata;
        ramp_seq_pkg::CMD_ON_DELAY: onDly_r <= cmd.wdata;
        ramp_seq_pkg::CMD_RISE: rise_r <= cmd.wdata;
        ramp_seq_pkg::CMD_OFF_DELAY: offDly_r <= cmd.wdata;
        ramp_seq_pkg::CMD_FALL: fall_r <= cmd.wdata;
        default: ;
      endcase
    end
  end

  // Read answer one cycle after the command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= ramp_seq_pkg::ZERO16;
      rdataValid_r <= 1'b0;
    end else if (ce) begin
      rdataValid_r <= cmdValid && !cmd.write;
      if (cmdValid && !cmd.write) rdata_r <= rdataSel;
    end
  end

  // ==========================================================
  // Power-good with hysteresis; both values share one Linear-16 scale
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pg_r <= 1'b0;
    end else if (ce) begin
      if (voutMeas > pgThresh_r) pg_r <= 1'b1;
      else if (voutMeas < uvFaultLimit) pg_r <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  // Fall shorter than 5 ms is treated as no controlled fall at all
  assign fallShort = ramp_seq_pkg::lin11Cycles(fall_r, 32'(CycPerMs)) <
                     64'(ramp_seq_pkg::FALL_MIN_MS) * 64'(CycPerMs);
  assign hardOff = multiPhase || fallShort;

  // One shared timer; each phase reloads it on entry
  assign timerCode = (state_nxt == ramp_seq_pkg::ST_ON_DLY) ? onDly_r :
                     (state_nxt == ramp_seq_pkg::ST_RISE) ? rise_r :
                     (state_nxt == ramp_seq_pkg::ST_OFF_DLY) ? offDly_r :
                     fall_r;
  assign timerStart = (state_nxt != state_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ramp_seq_pkg::ST_IDLE:
        if (outputEnable) state_nxt = ramp_seq_pkg::ST_ON_DLY;
      ramp_seq_pkg::ST_ON_DLY:
        if (!outputEnable) state_nxt = ramp_seq_pkg::ST_OFF_DLY;
        else if (timerDone) state_nxt = ramp_seq_pkg::ST_RISE;
      ramp_seq_pkg::ST_RISE:
        if (!outputEnable) state_nxt = ramp_seq_pkg::ST_OFF_DLY;
        else if (multiPhase ? multiRampDone : timerDone) begin
          state_nxt = ramp_seq_pkg::ST_ON;
        end
      ramp_seq_pkg::ST_ON:
        if (!outputEnable) state_nxt = ramp_seq_pkg::ST_OFF_DLY;
      ramp_seq_pkg::ST_OFF_DLY:
        if (timerDone) begin
          state_nxt = hardOff ? ramp_seq_pkg::ST_IDLE : ramp_seq_pkg::ST_FALL;
        end
      ramp_seq_pkg::ST_FALL:
        if (timerDone) state_nxt = ramp_seq_pkg::ST_IDLE;
      default: state_nxt = ramp_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ramp_seq_pkg::ST_IDLE;
      rampUp_r <= 1'b0;
      rampDown_r <= 1'b0;
      on_r <= 1'b0;
      off_r <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      rampUp_r <= (state_nxt == ramp_seq_pkg::ST_RISE);
      rampDown_r <= (state_nxt == ramp_seq_pkg::ST_FALL);
      on_r <= (state_nxt == ramp_seq_pkg::ST_ON);
      off_r <= (state_nxt == ramp_seq_pkg::ST_IDLE);
    end
  end

  lin11_timer #(.CycPerMs(CycPerMs)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(timerStart),
    .code(timerCode),
    .done(timerDone)
  );

  assign rdata = rdata_r;
  assign rdataValid = rdataValid_r;
  assign rampUp = rampUp_r;
  assign rampDown = rampDown_r;
  assign outputOn = on_r;
  assign switchesOff = off_r;
  assign powerGood = pg_r;

  // ==========================================================
  // Assertions
  property p_pgSet;
    @(posedge clk) disable iff (!rst_n) ce && voutMeas > pgThresh_r |=> powerGood;
  endproperty
  a_pgSet: assert property (p_pgSet) else $error("power-good not set");

  property p_pgClr;
    @(posedge clk) disable iff (!rst_n)
      ce && voutMeas < uvFaultLimit && voutMeas <= pgThresh_r |=> !powerGood;
  endproperty
  a_pgClr: assert property (p_pgClr) else $error("power-good not cleared");

  property p_resetVal;
    @(posedge clk) $rose(rst_n) |-> onDly_r == ramp_seq_pkg::TIME_RESET &&
      fall_r == ramp_seq_pkg::TIME_RESET && rise_r == ramp_seq_pkg::TIME_RESET;
  endproperty
  a_resetVal: assert property (p_resetVal) else $error("bad timing reset");

  property p_wp;
    @(posedge clk) disable iff (!rst_n)
      ce && cmdValid && cmd.write && writeProtect |=> $stable(onDly_r) && $stable(fall_r);
  endproperty
  a_wp: assert property (p_wp) else $error("write slipped past protect");

  property p_wr;
    @(posedge clk) disable iff (!rst_n)
      ce && wrOk && cmd.code == ramp_seq_pkg::CMD_ON_DELAY |=> onDly_r == $past(cmd.wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
      ce && (state_r == ramp_seq_pkg::ST_ON_DLY || state_r == ramp_seq_pkg::ST_RISE)
      && !outputEnable |=> state_r == ramp_seq_pkg::ST_OFF_DLY;
  endproperty
  a_abort: assert property (p_abort) else $error("turn-on not aborted");

  property p_hardOff;
    @(posedge clk) disable iff (!rst_n)
      ce && state_r == ramp_seq_pkg::ST_OFF_DLY && timerDone && hardOff
      |=> switchesOff && !rampDown;
  endproperty
  a_hardOff: assert property (p_hardOff) else $error("no immediate off");

  property p_mpRise;
    @(posedge clk) disable iff (!rst_n)
      ce && state_r == ramp_seq_pkg::ST_RISE && multiPhase && outputEnable && !multiRampDone
      |=> state_r == ramp_seq_pkg::ST_RISE;
  endproperty
  a_mpRise: assert property (p_mpRise) else $error("rise time used in multi-phase");

  property p_riseAfterDly;
    @(posedge clk) disable iff (!rst_n)
      $rose(rampUp) |-> $past(state_r) == ramp_seq_pkg::ST_ON_DLY;
  endproperty
  a_riseAfterDly: assert property (p_riseAfterDly) else $error("rise out of order");

  c_fullOn: cover property (@(posedge clk) disable iff (!rst_n) $rose(outputOn));
  c_fall: cover property (@(posedge clk) disable iff (!rst_n) $rose(rampDown));
  c_abort: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == ramp_seq_pkg::ST_RISE && !outputEnable);
endmodule

// ### output_ramp_sequencer_bench.sv
/*
  Self-checking bench for the output ramp sequencer: register reset values,
  read/write, write protection, power-good hysteresis and the on/off sequence.
  Assumes the package is compiled first; runs the design with CycPerMs = 4.
*/
`timescale 1ns/1ps
module output_ramp_sequencer_bench;
  // ==========================================================
  // Signals
  localparam int CPM = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cmdValid = 1'b0;
  ramp_seq_pkg::cmd_s cmd = '0;
  logic writeProtect = 1'b0;
  logic outputEnable = 1'b0;
  logic multiPhase = 1'b0;
  logic multiRampDone = 1'b0;
  logic [15:0] setpointStrap = 16'h0000;
  logic [15:0] voutMeas = 16'h0000;
  logic [15:0] uvFaultLimit = 16'h0C00;
  logic [15:0] rdata;
  logic rdataValid, rampUp, rampDown, outputOn, switchesOff, powerGood;
  int error_cnt = 0;
  int compares = 0;
  int seed = 24835;
  logic sawUp = 1'b0;
  logic sawDown = 1'b0;
  logic [15:0] v [5];
  logic [7:0] codes [5] = '{ramp_seq_pkg::CMD_PG_THRESH, ramp_seq_pkg::CMD_ON_DELAY,
    ramp_seq_pkg::CMD_RISE, ramp_seq_pkg::CMD_OFF_DELAY, ramp_seq_pkg::CMD_FALL};

  output_ramp_sequencer #(.CycPerMs(CPM)) u_output_ramp_sequencer (.clk(clk), .rst_n(rst_n),
    .ce(ce), .cmdValid(cmdValid), .cmd(cmd), .writeProtect(writeProtect),
    .outputEnable(outputEnable), .multiPhase(multiPhase), .multiRampDone(multiRampDone),
    .setpointStrap(setpointStrap), .voutMeas(voutMeas), .uvFaultLimit(uvFaultLimit),
    .rdata(rdata), .rdataValid(rdataValid), .rampUp(rampUp), .rampDown(rampDown),
    .outputOn(outputOn), .switchesOff(switchesOff), .powerGood(powerGood));

  // ==========================================================
  // Clock and ramp monitors; monitors catch pulses between polls
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (rampUp === 1'b1) sawUp = 1'b1;
    if (rampDown === 1'b1) sawDown = 1'b1;
  end

  // ==========================================================
  // Helpers
  task stop_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] expv, input logic [31:0] got);
    compares++;
    if (got !== expv) begin
      $display("BAD %s expected %h seen %h", name, expv, got);
      error_cnt++;
    end
  endtask

  // Linear-11 code to cycles; negative mantissa means zero, floor of one cycle
  function automatic int expCyc(input logic [15:0] c);
    int y;
    int n;
    int t;
    y = c[10] ? 0 : int'(c[9:0]);
    n = int'($signed(c[15:11]));
    t = (n >= 0) ? ((y * CPM) <<< n) : ((y * CPM) >>> (-n));
    return (t < 1) ? 1 : t;
  endfunction

  function automatic logic sig(input int w);
    case (w)
      0: return rampUp;
      1: return outputOn;
      2: return rampDown;
      default: return switchesOff;
    endcase
  endfunction

  // One command, held for exactly the taking edge
  task access(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= '{w, c, d};
    @(posedge clk);
    cmdValid <= 1'b0;
    #1;
  endtask

  task rd(input string name, input logic [7:0] c, input logic [15:0] expv);
    access(1'b0, c, 16'h0000);
    chk({name, " valid"}, 32'h1, {31'h0, rdataValid});
    chk(name, {16'h0, expv}, {16'h0, rdata});
  endtask

  // Bounded wait; a few cycles of slack cover pipeline latency only
  task waitFor(input string name, input int which, input int t);
    int cnt;
    cnt = 0;
    while (sig(which) !== 1'b1 && cnt < t + 20) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(name, t, (cnt >= t && cnt <= t + 5) ? t : cnt);
  endtask

  task pgStep(input logic [15:0] vm, input logic expv);
    @(posedge clk);
    voutMeas <= vm;
    repeat (2) @(posedge clk);
    #1;
    chk("power good", {31'h0, expv}, {31'h0, powerGood});
  endtask

  // Full on/off cycle with a random turn-on delay
  task seqCycle(input logic [15:0] fallCode, input logic mp);
    logic [15:0] onC;
    logic shortFall;
    onC = 16'(1 + ($random(seed) & 7));
    access(1'b1, ramp_seq_pkg::CMD_ON_DELAY, onC);
    access(1'b1, ramp_seq_pkg::CMD_RISE, 16'h0002);
    access(1'b1, ramp_seq_pkg::CMD_OFF_DELAY, 16'h0001);
    access(1'b1, ramp_seq_pkg::CMD_FALL, fallCode);
    shortFall = mp || (expCyc(fallCode) < 5 * CPM);
    @(posedge clk);
    multiPhase <= mp;
    outputEnable <= 1'b1;
    sawDown = 1'b0;
    #1;
    waitFor("turn-on delay", 0, expCyc(onC));
    chk("switches on", 0, switchesOff);
    if (mp) begin
      repeat (3 * expCyc(16'h0002)) @(posedge clk);
      multiRampDone <= 1'b1;
      #1;
      chk("rise register ignored", 1, rampUp);
      @(posedge clk);
      multiRampDone <= 1'b0;
      #1;
      waitFor("ramp gain end", 1, 0);
    end else begin
      waitFor("rise time", 1, expCyc(16'h0002));
    end
    chk("rise ended", 0, rampUp);
    @(posedge clk);
    outputEnable <= 1'b0;
    #1;
    if (shortFall) begin
      waitFor("immediate off", 3, expCyc(16'h0001));
      chk("no fall ramp", 0, sawDown);
    end else begin
      waitFor("turn-off delay", 2, expCyc(16'h0001));
      chk("on cleared", 0, outputOn);
      waitFor("fall time", 3, expCyc(fallCode));
    end
    $display("test sequence fall %h multi %0d done", fallCode, mp);
  endtask

  // ==========================================================
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("BAD watchdog expected finish seen timeout");
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    setpointStrap = 16'($random(seed));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("idle switches off", 1, switchesOff);
    rd("threshold reset", codes[0], 16'((32'(setpointStrap) * 9) / 10));
    for (int i = 1; i < 5; i++) rd("timing reset", codes[i], ramp_seq_pkg::TIME_RESET);
    for (int i = 0; i < 5; i++) begin
      v[i] = 16'($random(seed));
      access(1'b1, codes[i], v[i]);
    end
    @(posedge clk);
    writeProtect <= 1'b1;
    for (int i = 0; i < 5; i++) access(1'b1, codes[i], ~v[i]);
    @(posedge clk);
    writeProtect <= 1'b0;
    for (int i = 0; i < 5; i++) rd("readback", codes[i], v[i]);
    access(1'b1, 8'h62, 16'hA5A5);
    rd("unmapped", 8'h62, 16'h0000);
    $display("test registers done");
    access(1'b1, codes[0], 16'h1000);
    v[0] = 16'h0C00 + 16'($random(seed) & 16'h03FF);
    pgStep(16'h1000, 1'b0);
    pgStep(16'h1001, 1'b1);
    pgStep(v[0], 1'b1);
    pgStep(16'h0C00, 1'b1);
    pgStep(16'h0BFF, 1'b0);
    pgStep(v[0], 1'b0);
    $display("test power good done");
    seqCycle(ramp_seq_pkg::TIME_RESET, 1'b0);
    seqCycle(16'h0004, 1'b0);
    seqCycle(ramp_seq_pkg::TIME_RESET, 1'b1);
    access(1'b1, codes[1], 16'h0008);
    @(posedge clk);
    outputEnable <= 1'b1;
    sawUp = 1'b0;
    repeat (5) @(posedge clk);
    outputEnable <= 1'b0;
    #1;
    waitFor("abort off", 3, expCyc(16'h0001));
    chk("aborted rise", 0, sawUp);
    // Abort in mid-rise, with a clock-enable freeze held longer than the rise
    access(1'b1, codes[1], 16'h0001);
    access(1'b1, codes[2], 16'h0008);
    @(posedge clk);
    multiPhase <= 1'b0;
    outputEnable <= 1'b1;
    #1;
    waitFor("abort rise start", 0, expCyc(16'h0001));
    @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("frozen in rise", 1, rampUp);
    chk("frozen not on", 0, outputOn);
    @(posedge clk);
    ce <= 1'b1;
    outputEnable <= 1'b0;
    #1;
    waitFor("abort rise off delay", 2, expCyc(16'h0001));
    chk("never fully on", 0, outputOn);
    waitFor("abort rise fall", 3, expCyc(ramp_seq_pkg::TIME_RESET));
    $display("test abort done");
    stop_test();
  end
endmodule
